// [logic/osc_pkg.sv]
// shared constants and types for the oscillator control and status block
package osc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MAIN_CLK_STATUS = 8'h03;
  localparam logic [7:0] IDX_FAST_INT_CTRL = 8'h08;
  localparam logic [7:0] IDX_HF_AUTO_TUNING_MODE_STATUS = 8'h0A;
  localparam logic [7:0] IDX_INT_SLOW_CTRL = 8'h18;
  localparam logic [7:0] IDX_EXT_SLOW_CTRL = 8'h1C;
  localparam logic [7:0] IDX_EXT_FAST_CTRL = 8'h20;
  localparam logic [7:0] IDX_USB_PLL_STATUS = 8'h25;
  localparam logic [7:0] IDX_CCP_KEY = 8'h30;

  // reset values
  localparam logic [1:0] RST_TUNE_MODE = 2'h0;
  localparam logic [7:0] RST_INT_SLOW_CTRL = 8'h00;
  localparam logic [7:0] RST_EXT_SLOW_CTRL = 8'h00;
  localparam logic [7:0] RST_EXT_FAST_CTRL = 8'h00;

  // field positions
  localparam int BIT_RUN_STANDBY = 7;
  localparam int SLOW_SU_LSB = 4;
  localparam int SLOW_SEL_BIT = 2;
  localparam int SLOW_LP_BIT = 1;
  localparam int OSC_ENABLE_BIT = 0;
  localparam int FAST_SU_LSB = 4;
  localparam int FAST_FRQ_LSB = 2;
  localparam int FAST_SEL_BIT = 1;
  localparam int TUNE_MODE_LSB = 0;
  localparam int LOCK_BIT = 1;
  localparam int SYNC_BIT = 0;
  localparam int MCS_FAST_BIT = 4;
  localparam int MCS_SLOW_BIT = 3;
  localparam int MCS_INT_SLOW_BIT = 2;
  localparam int PLL_BIT = 0;
  localparam int CCP_OPEN_BIT = 0;

  // unlock key for protected writes, value arbitrary
  localparam logic [7:0] CCP_KEY = 8'hD8;
  localparam logic [2:0] CCP_WINDOW_CYCLES = 3'h4;

  // timing of the 1 MHz synchronisation domain
  localparam int CORE_PERIOD_NS = 50;
  localparam int SYNC_PERIOD_NS = 1000;
  localparam logic [4:0] SYNC_DIV = 5'(SYNC_PERIOD_NS / CORE_PERIOD_NS);
  localparam logic [1:0] SYNC_TICKS = 2'h2;

  // oscillator cycle counts
  localparam int INT_SLOW_AVAIL = 4;
  localparam int EXT_SLOW_AVAIL = 3;
  localparam int EXT_FAST_AVAIL = 2;
  localparam logic [16:0] SLOW_SU_1K = 17'h00400;
  localparam logic [16:0] SLOW_SU_16K = 17'h04000;
  localparam logic [16:0] SLOW_SU_32K = 17'h08000;
  localparam logic [16:0] SLOW_SU_64K = 17'h10000;
  localparam logic [16:0] FAST_SU_256 = 17'h00100;
  localparam logic [16:0] FAST_SU_1K = 17'h00400;
  localparam logic [16:0] FAST_SU_4K = 17'h01000;
  localparam logic [16:0] EXT_CLK_SU = 17'h00001;
  localparam logic [16:0] INT_SLOW_SU = 17'h00001;

  typedef logic [16:0] osc_count_type;

  typedef enum logic [1:0] {
    TUNE_OFF = 2'b00,
    TUNE_SLOW_XTAL = 2'b01,
    TUNE_USB_SOF = 2'b10,
    TUNE_RSVD = 2'b11
  } osc_tune_mode_type;

  typedef enum logic [1:0] {
    SLEEP_ACTIVE = 2'b00,
    SLEEP_IDLE = 2'b01,
    SLEEP_STANDBY = 2'b10,
    SLEEP_POWER_DOWN = 2'b11
  } osc_sleep_type;

  typedef enum logic [1:0] {
    FRQ_8M = 2'b00,
    FRQ_16M = 2'b01,
    FRQ_24M = 2'b10,
    FRQ_32M = 2'b11
  } osc_frq_range_type;

endpackage

// [logic/osc_gate.sv]
// start-up and availability sequencing for one oscillator
`timescale 1ns/1ns
module osc_gate #(
  parameter int AVAIL_CYCLES = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic request,
  input wire osc_pkg::osc_count_type startup,
  // oscillator output sampled as a level
  input wire logic osc_clk_in,
  // status
  output logic stable,
  output logic available
);
  import osc_pkg::*;

  logic osc_d;
  logic osc_edge;
  osc_count_type su_cnt;
  logic [2:0] av_cnt;

  // edge of the oscillator output, seen on the core clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_d <= 1'b0;
    end else begin
      osc_d <= osc_clk_in;
    end
  end
  assign osc_edge = osc_clk_in & ~osc_d;

  // start-up count; a stopped oscillator must start over from zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      su_cnt <= '0;
      stable <= 1'b0;
    end else if (!run) begin
      su_cnt <= '0;
      stable <= 1'b0;
    end else if (osc_edge && !stable) begin
      su_cnt <= osc_count_type'(su_cnt + 17'h00001);
      stable <= (osc_count_type'(su_cnt + 17'h00001) >= startup);
    end
  end

  // output held back until the consumer has waited its cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      av_cnt <= '0;
      available <= 1'b0;
    end else if (!run || !request || !stable) begin
      av_cnt <= '0;
      available <= 1'b0;
    end else if (osc_edge && !available) begin
      av_cnt <= 3'(av_cnt + 3'h1);
      available <= (32'(av_cnt) + 1 >= AVAIL_CYCLES);
    end
  end

  // request is judged at the edge that raised available, not one later
  a_avail_needs_stable: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(available) |-> $past(stable && request))
    else $error("output given before start-up ended");

  a_stop_clears_all: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !run |=> !stable && !available)
    else $error("stopped oscillator still flagged");

endmodule

// [logic/osc_ctrl.sv]
// register block for oscillator control and status, apb slave
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
// What this block does
// - lock flag high while selected tuning algorithm is locked, else low.
// - sync flag reads 0 while a new tuning mode crosses to 1 MHz.
// - internal slow oscillator runs on request, or always when kept.
// - internal slow output reaches a requester after four of its cycles.
// - external slow runs on request in active/idle, or always when kept.
// - external slow output available within three cycles after start-up.
// - slow start-up field picks 1k, 16k, 32k or 64k cycles.
// - slow start-up and source bits ignore writes while enabled or stable.
// - slow source bit picks crystal on both pins or clock on pin one.
// - slow low-power bit puts that oscillator in reduced-power mode.
// - slow enable starts oscillator and takes its pins from port logic.
// - fast external runs on request or when kept, in all but power-down.
// - fast external output reaches a requester after two of its cycles.
// - fast start-up field picks 256, 1K or 4K cycles; 3 reserved.
// - fast start-up and source bits ignore writes while enabled or stable.
// - fast range field sets max crystal of 8, 16, 24 or 32 MHz.
// - fast source bit picks crystal on both pins or clock on pin one.
// - fast enable starts oscillator and overrides port control of pins.
// - pll status bit 0 reads 1 while the usb pll runs.
// - requesters get an oscillator only after its start-up delay.
// - tuning mode 0 off, 1 against slow crystal, 2 against usb frames.
// - slow stable status reads 1 when crystal stable or clock running.
module osc_ctrl #(
  parameter int ADDR_W = 12,
  parameter int SU_SHIFT = 0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system state and clock requests
  input wire osc_pkg::osc_sleep_type sleep_mode,
  input wire logic req_int_slow,
  input wire logic req_ext_slow,
  input wire logic req_ext_fast,
  // oscillator outputs sampled as levels
  input wire logic int_slow_osc_clk,
  input wire logic ext_slow_osc_clk,
  input wire logic ext_fast_osc_clk,
  // tuning and pll status from the analog side
  input wire logic tune_lock_in,
  input wire logic pll_running_in,
  // oscillator and pin control
  output logic int_slow_run,
  output logic ext_slow_run,
  output logic ext_fast_run,
  output logic slow_pin_override,
  output logic slow_pin_two_crystal,
  output logic slow_crystal_low_power,
  output logic fast_pin_override,
  output logic fast_pin_two_crystal,
  output osc_pkg::osc_frq_range_type fast_crystal_max_frequency,
  output osc_pkg::osc_tune_mode_type tune_mode_active,
  // clock availability to consumers
  output logic int_slow_available,
  output logic ext_slow_available,
  output logic ext_fast_available
);
  import osc_pkg::*;

  localparam int SYNC_MAX = 41;

  logic [7:0] int_slow_ctrl;
  logic [7:0] ext_slow_ctrl;
  logic [7:0] ext_fast_ctrl;
  osc_tune_mode_type auto_tuning_mode;
  logic [2:0] ccp_cnt;
  logic ccp_open;
  logic [4:0] div_cnt;
  logic sync_tick;
  logic [1:0] sync_left;
  logic sync_busy;
  logic tune_locked_flag;
  logic pll_running_flag;
  logic int_slow_stable;
  logic slow_external_stable_flag;
  logic fast_external_stable_flag;
  logic wr;
  logic hit;
  logic [31:0] next_prdata;
  logic [7:0] wd;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction

  // shift lets a simulation shorten long start-up counts; never below one
  function automatic osc_count_type su_scale(input osc_count_type n);
    osc_count_type s;
    s = osc_count_type'(n >> SU_SHIFT);
    return (s == '0) ? EXT_CLK_SU : s;
  endfunction

  function automatic osc_count_type slow_su(input logic [1:0] f,
                                            input logic sel);
    osc_count_type n;
    n = SLOW_SU_1K;
    unique case (f)
      2'h0: n = SLOW_SU_1K;
      2'h1: n = SLOW_SU_16K;
      2'h2: n = SLOW_SU_32K;
      2'h3: n = SLOW_SU_64K;
    endcase
    return sel ? EXT_CLK_SU : su_scale(n);
  endfunction

  // reserved code 3 is treated as the longest wait
  function automatic osc_count_type fast_su(input logic [1:0] f,
                                            input logic sel);
    osc_count_type n;
    n = FAST_SU_256;
    unique case (f)
      2'h0: n = FAST_SU_256;
      2'h1: n = FAST_SU_1K;
      2'h2: n = FAST_SU_4K;
      2'h3: n = FAST_SU_4K;
    endcase
    return sel ? EXT_CLK_SU : su_scale(n);
  endfunction

  // a write lands at the access edge with pready high
  assign wr = psel & penable & pready & pwrite;
  assign wd = pwdata[7:0];
  assign ccp_open = (ccp_cnt != 3'h0);

  // unlock window opened by the key and counted down
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ccp_cnt <= 3'h0;
    end else if (wr && paddr == byte_addr(IDX_CCP_KEY) && wd == CCP_KEY) begin
      ccp_cnt <= CCP_WINDOW_CYCLES;
    end else if (ccp_open) begin
      ccp_cnt <= 3'(ccp_cnt - 3'h1);
    end
  end

  // internal slow control; only the keep bit exists
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_slow_ctrl <= RST_INT_SLOW_CTRL;
    end else if (wr && ccp_open && paddr == byte_addr(IDX_INT_SLOW_CTRL)) begin
      int_slow_ctrl <= {wd[BIT_RUN_STANDBY], 7'h00};
    end
  end

  // external slow control; timing and source frozen while in use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_slow_ctrl <= RST_EXT_SLOW_CTRL;
    end else if (wr && ccp_open && paddr == byte_addr(IDX_EXT_SLOW_CTRL)) begin
      ext_slow_ctrl[BIT_RUN_STANDBY] <= wd[BIT_RUN_STANDBY];
      ext_slow_ctrl[SLOW_LP_BIT] <= wd[SLOW_LP_BIT];
      ext_slow_ctrl[OSC_ENABLE_BIT] <= wd[OSC_ENABLE_BIT];
      if (!ext_slow_ctrl[OSC_ENABLE_BIT] && !slow_external_stable_flag) begin
        ext_slow_ctrl[SLOW_SU_LSB+:2] <= wd[SLOW_SU_LSB+:2];
        ext_slow_ctrl[SLOW_SEL_BIT] <= wd[SLOW_SEL_BIT];
      end
    end
  end

  // external fast control; timing and source frozen while in use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_fast_ctrl <= RST_EXT_FAST_CTRL;
    end else if (wr && ccp_open && paddr == byte_addr(IDX_EXT_FAST_CTRL)) begin
      ext_fast_ctrl[BIT_RUN_STANDBY] <= wd[BIT_RUN_STANDBY];
      ext_fast_ctrl[FAST_FRQ_LSB+:2] <= wd[FAST_FRQ_LSB+:2];
      ext_fast_ctrl[OSC_ENABLE_BIT] <= wd[OSC_ENABLE_BIT];
      if (!ext_fast_ctrl[OSC_ENABLE_BIT] && !fast_external_stable_flag) begin
        ext_fast_ctrl[FAST_SU_LSB+:2] <= wd[FAST_SU_LSB+:2];
        ext_fast_ctrl[FAST_SEL_BIT] <= wd[FAST_SEL_BIT];
      end
    end
  end

  // tuning mode written on the core side; reserved code stored as written
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_tuning_mode <= osc_tune_mode_type'(RST_TUNE_MODE);
    end else if (wr && ccp_open && paddr == byte_addr(IDX_FAST_INT_CTRL)) begin
      auto_tuning_mode <= osc_tune_mode_type'(wd[TUNE_MODE_LSB+:2]);
    end
  end

  // 1 MHz tick from the 20 MHz core clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 5'h00;
      sync_tick <= 1'b0;
    end else if (div_cnt == 5'(SYNC_DIV - 5'h01)) begin
      div_cnt <= 5'h00;
      sync_tick <= 1'b1;
    end else begin
      div_cnt <= 5'(div_cnt + 5'h01);
      sync_tick <= 1'b0;
    end
  end

  // mode crossing: a new write restarts the count, so it is never lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_left <= 2'h0;
      tune_mode_active <= TUNE_OFF;
    end else if (wr && ccp_open && paddr == byte_addr(IDX_FAST_INT_CTRL)) begin
      sync_left <= SYNC_TICKS;
    end else if (sync_tick && sync_left != 2'h0) begin
      sync_left <= 2'(sync_left - 2'h1);
      if (sync_left == 2'h1) begin
        tune_mode_active <= auto_tuning_mode;
      end
    end
  end
  assign sync_busy = (sync_left != 2'h0);

  // lock only counts for a real algorithm that has finished crossing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tune_locked_flag <= 1'b0;
      pll_running_flag <= 1'b0;
    end else begin
      tune_locked_flag <= tune_lock_in & ~sync_busy &
        (tune_mode_active == TUNE_SLOW_XTAL ||
         tune_mode_active == TUNE_USB_SOF);
      pll_running_flag <= pll_running_in;
    end
  end

  // oscillator run decisions per sleep mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_slow_run <= 1'b0;
      ext_slow_run <= 1'b0;
      ext_fast_run <= 1'b0;
    end else begin
      int_slow_run <= int_slow_ctrl[BIT_RUN_STANDBY] | req_int_slow;
      ext_slow_run <= ext_slow_ctrl[OSC_ENABLE_BIT] &
        (ext_slow_ctrl[BIT_RUN_STANDBY] | (req_ext_slow &
         (sleep_mode == SLEEP_ACTIVE || sleep_mode == SLEEP_IDLE)));
      ext_fast_run <= ext_fast_ctrl[OSC_ENABLE_BIT] &
        (ext_fast_ctrl[BIT_RUN_STANDBY] | req_ext_fast) &
        (sleep_mode != SLEEP_POWER_DOWN);
    end
  end

  // pin and analog controls follow the stored fields
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_pin_override <= 1'b0;
      slow_pin_two_crystal <= 1'b0;
      slow_crystal_low_power <= 1'b0;
      fast_pin_override <= 1'b0;
      fast_pin_two_crystal <= 1'b0;
      fast_crystal_max_frequency <= FRQ_8M;
    end else begin
      slow_pin_override <= ext_slow_ctrl[OSC_ENABLE_BIT];
      slow_pin_two_crystal <= ext_slow_ctrl[OSC_ENABLE_BIT] &
        ~ext_slow_ctrl[SLOW_SEL_BIT];
      slow_crystal_low_power <= ext_slow_ctrl[SLOW_LP_BIT];
      fast_pin_override <= ext_fast_ctrl[OSC_ENABLE_BIT];
      fast_pin_two_crystal <= ext_fast_ctrl[OSC_ENABLE_BIT] &
        ~ext_fast_ctrl[FAST_SEL_BIT];
      fast_crystal_max_frequency <=
        osc_frq_range_type'(ext_fast_ctrl[FAST_FRQ_LSB+:2]);
    end
  end

  // start-up and availability sequencers; a consumer sees its clock late
  osc_gate #(.AVAIL_CYCLES(INT_SLOW_AVAIL)) u_int_slow (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(int_slow_run),
    .request(req_int_slow),
    .startup(INT_SLOW_SU),
    .osc_clk_in(int_slow_osc_clk),
    .stable(int_slow_stable),
    .available(int_slow_available)
  );

  osc_gate #(.AVAIL_CYCLES(EXT_SLOW_AVAIL)) u_ext_slow (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(ext_slow_run),
    .request(req_ext_slow),
    .startup(slow_su(ext_slow_ctrl[SLOW_SU_LSB+:2],
                     ext_slow_ctrl[SLOW_SEL_BIT])),
    .osc_clk_in(ext_slow_osc_clk),
    .stable(slow_external_stable_flag),
    .available(ext_slow_available)
  );

  osc_gate #(.AVAIL_CYCLES(EXT_FAST_AVAIL)) u_ext_fast (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(ext_fast_run),
    .request(req_ext_fast),
    .startup(fast_su(ext_fast_ctrl[FAST_SU_LSB+:2],
                     ext_fast_ctrl[FAST_SEL_BIT])),
    .osc_clk_in(ext_fast_osc_clk),
    .stable(fast_external_stable_flag),
    .available(ext_fast_available)
  );

  // read mux; unmapped addresses answer with an error and zero data
  always_comb begin
    next_prdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      byte_addr(IDX_MAIN_CLK_STATUS): begin
        next_prdata[MCS_FAST_BIT] = fast_external_stable_flag;
        next_prdata[MCS_SLOW_BIT] = slow_external_stable_flag;
        next_prdata[MCS_INT_SLOW_BIT] = int_slow_stable;
      end
      byte_addr(IDX_FAST_INT_CTRL):
        next_prdata[TUNE_MODE_LSB+:2] = auto_tuning_mode;
      byte_addr(IDX_HF_AUTO_TUNING_MODE_STATUS): begin
        next_prdata[LOCK_BIT] = tune_locked_flag;
        next_prdata[SYNC_BIT] = ~sync_busy;
      end
      byte_addr(IDX_INT_SLOW_CTRL): next_prdata[7:0] = int_slow_ctrl;
      byte_addr(IDX_EXT_SLOW_CTRL): next_prdata[7:0] = ext_slow_ctrl;
      byte_addr(IDX_EXT_FAST_CTRL): next_prdata[7:0] = ext_fast_ctrl;
      byte_addr(IDX_USB_PLL_STATUS):
        next_prdata[PLL_BIT] = pll_running_flag;
      byte_addr(IDX_CCP_KEY): next_prdata[CCP_OPEN_BIT] = ccp_open;
      default: hit = 1'b0;
    endcase
  end

  // no wait state; prdata and pready come straight from flops loaded in the setup cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~hit;
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  sequence s_tune_write;
    wr && ccp_open && paddr == byte_addr(IDX_FAST_INT_CTRL);
  endsequence

  sequence s_sync_done;
    ##[1:SYNC_MAX] !sync_busy;
  endsequence

  a_sync_low_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_tune_write |=> sync_busy)
    else $error("sync flag not cleared by mode write");

  a_sync_bound: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_tune_write |=> s_sync_done)
    else $error("mode crossing took too long");

  a_lock_gated: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    tune_locked_flag |-> $past(tune_lock_in) && tune_mode_active != TUNE_OFF)
    else $error("lock flag without locked algorithm");

  a_ccp_blocks: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr && !ccp_open |=> $stable(ext_fast_ctrl) && $stable(ext_slow_ctrl)
      && $stable(int_slow_ctrl))
    else $error("protected write took effect while locked");

  a_slow_su_frozen: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ext_slow_ctrl[OSC_ENABLE_BIT] |=>
      $stable(ext_slow_ctrl[SLOW_SU_LSB+:2]) &&
      $stable(ext_slow_ctrl[SLOW_SEL_BIT]))
    else $error("slow start-up or source changed while enabled");

  a_fast_su_frozen: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    fast_external_stable_flag |=>
      $stable(ext_fast_ctrl[FAST_SU_LSB+:2]) &&
      $stable(ext_fast_ctrl[FAST_SEL_BIT]))
    else $error("fast start-up or source changed while stable");

  a_fast_pd_stop: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sleep_mode == SLEEP_POWER_DOWN |=> !ext_fast_run)
    else $error("fast oscillator kept in power-down");

  a_pin_follow: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ##2 slow_pin_override == $past(ext_slow_ctrl[OSC_ENABLE_BIT]))
    else $error("slow pin override not following enable");

  a_pll_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ##1 pll_running_flag == $past(pll_running_in))
    else $error("pll flag not following pll");

endmodule

// [verif/osc_src_model.sv]
// oscillator sources on the pins: clocks stand still while not run
`timescale 1ns/1ns
module osc_src_model (
  // clock
  input wire logic core_clk,
  // run controls from the block
  input wire logic int_run,
  input wire logic ext_slow_run,
  input wire logic ext_fast_run,
  // oscillator outputs
  output logic int_slow_osc_clk,
  output logic ext_slow_osc_clk,
  output logic ext_fast_osc_clk
);
  logic [2:0] phase = 3'h0;
  // free divider; slow sources at 1/8, fast at 1/4 of core_clk
  always @(posedge core_clk) begin
    phase <= phase + 3'h1;
  end
  // a stopped oscillator rests low, never a stale high
  assign int_slow_osc_clk = int_run & phase[2];
  assign ext_slow_osc_clk = ext_slow_run & phase[2];
  assign ext_fast_osc_clk = ext_fast_run & phase[1];
endmodule

// [verif/tb_oscillator_control_status.sv]
// self-checking bench for the oscillator control block
`timescale 1ns/1ns
module tb_oscillator_control_status;
  import osc_pkg::*;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic pready, pslverr, err;
  osc_sleep_type sleep_mode = SLEEP_ACTIVE;
  logic req_is = 0, req_es = 0, req_ef = 0, lock_in = 0, pll_in = 0;
  logic isc, esc, efc, isr, esr, efr, spo, sp2, slp, fpo, fp2;
  logic [2:0] av;
  osc_frq_range_type frq;
  osc_tune_mode_type tma;
  int failures = 0, cmp_count = 0;
  logic [31:0] seed = 32'h5E9CA8C1;
  osc_ctrl #(.ADDR_W(12), .SU_SHIFT(10)) i_osc_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .req_int_slow(req_is), .req_ext_slow(req_es), .req_ext_fast(req_ef),
    .int_slow_osc_clk(isc), .ext_slow_osc_clk(esc),
    .ext_fast_osc_clk(efc), .tune_lock_in(lock_in),
    .pll_running_in(pll_in), .int_slow_run(isr), .ext_slow_run(esr),
    .ext_fast_run(efr), .slow_pin_override(spo),
    .slow_pin_two_crystal(sp2), .slow_crystal_low_power(slp),
    .fast_pin_override(fpo), .fast_pin_two_crystal(fp2),
    .fast_crystal_max_frequency(frq), .tune_mode_active(tma),
    .int_slow_available(av[0]), .ext_slow_available(av[1]),
    .ext_fast_available(av[2]));
  osc_src_model i_osc_src_model (
    .core_clk(core_clk), .int_run(isr), .ext_slow_run(esr),
    .ext_fast_run(efr), .int_slow_osc_clk(isc),
    .ext_slow_osc_clk(esc), .ext_fast_osc_clk(efc));
  // 50 ns clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // protected write: unlock key first, then the write
  task automatic prot(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, 12'h0C0, CCP_KEY);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string n, input logic [11:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(n, e, rd);
  endtask
  // bounded wait for one availability output
  task automatic wait_av(input int i);
    int k;
    k = 0;
    while (av[i] !== 1'b1 && k < 200) begin
      @(posedge core_clk);
      k++;
    end
    chk("available", 32'h1, {31'h0, av[i]});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog sized well past the whole sequence
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk("int_ctrl", 12'h060, 32'h0);
    rdchk("ext_slow", 12'h070, 32'h0);
    rdchk("ext_fast", 12'h080, 32'h0);
    rdchk("unmapped", 12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, 12'h070, 8'h05);
    rdchk("locked_wr", 12'h070, 32'h0);
    prot(12'h070, 8'h05);
    rdchk("slow_en", 12'h070, 32'h5);
    chk("slow_pins", 32'h2, {30'h0, spo, sp2});
    // keep bit is 0, so the source only runs once someone asks for it
    req_es <= 1'b1;
    repeat (40) @(posedge core_clk);
    apb(1'b0, 12'h00C, 8'h00);
    chk("slow_stable", 32'h1, {31'h0, rd[3]});
    prot(12'h070, 8'h31);
    rdchk("frozen", 12'h070, 32'h5);
    sleep_mode <= SLEEP_STANDBY;
    req_es <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("standby_off", 32'h0, {31'h0, esr});
    sleep_mode <= SLEEP_ACTIVE;
    wait_av(1);
    prot(12'h070, 8'h87);
    sleep_mode <= SLEEP_POWER_DOWN;
    repeat (4) @(posedge core_clk);
    chk("keep_run", 32'h3, {30'h0, esr, slp});
    prot(12'h060, 8'h80);
    req_is <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("int_run", 32'h2, {30'h0, isr, av[0]});
    wait_av(0);
    sleep_mode <= SLEEP_ACTIVE;
    v = rnd();
    // fast source never becomes the main clock here, so no prescaling
    prot(12'h080, {4'h0, v[1:0], 2'b01});
    repeat (2) @(posedge core_clk);
    chk("range", {30'h0, v[1:0]}, {30'h0, frq});
    chk("fast_pins", 32'h3, {30'h0, fpo, fp2});
    req_ef <= 1'b1;
    wait_av(2);
    prot(12'h080, 8'h33);
    rdchk("fast_frozen", 12'h080, 32'h1);
    sleep_mode <= SLEEP_POWER_DOWN;
    repeat (3) @(posedge core_clk);
    chk("fast_pd", 32'h0, {31'h0, efr});
    sleep_mode <= SLEEP_ACTIVE;
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      pll_in <= v[0];
      rdchk("pll", 12'h094, {31'h0, v[0]});
    end
    prot(12'h020, 8'h01);
    apb(1'b0, 12'h028, 8'h00);
    chk("syncing", 32'h0, {31'h0, rd[0]});
    lock_in <= 1'b1;
    repeat (60) @(posedge core_clk);
    rdchk("locked", 12'h028, 32'h3);
    chk("mode", {30'h0, TUNE_SLOW_XTAL}, {30'h0, tma});
    print_verdict();
  end
endmodule
